// ### logic/irq_status_defines.vh
// register offsets, field positions and reset values of the interrupt status block
`ifndef IRQ_STATUS_DEFINES_VH
`define IRQ_STATUS_DEFINES_VH

// register indices as printed, byte address is four times the index
`define REG_STATUS_IDX        8'h06
`define REG_LINE_A_CTRL_IDX   8'h07
`define REG_IRQ_MASK_IDX      8'h09
`define REG_IRQ_PEND_IDX      8'h0A

// status bit positions
`define ST_LINE_A             0
`define ST_LINE_B             1
`define ST_OFLOW              2
`define ST_UFLOW              3
`define ST_LOCK               4
`define ST_WIDTH              5

// control field positions
`define CT_LATCH_SEL          0
`define CT_OFLOW_EN           1
`define CT_UFLOW_EN           2
`define CT_LOCK_EN            3
`define CT_INVERT             4
`define CT_SEL_LO             5
`define CT_SEL_HI             7

// reset values
`define CTRL_RESET            8'h00
`define MASK_RESET            5'h00

`endif

// ### logic/sticky_flag.v
// one sticky event flag whose set wins over a clear in the same cycle
module sticky_flag (
  // clock and reset
  input  wire MCLK,
  input  wire RST_B,
  // event and clear
  input  wire set,
  input  wire clear,
  // state
  output reg  flag
);

  // hold until cleared, event in the clear cycle survives
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clear)
      flag <= 1'b0;
  end

endmodule // sticky_flag

// ### logic/display_interrupt_status_ctrl.v
// interrupt status register and first interrupt line control with APB slave
//
// Contract
// - status bit 0 records line A firing, cleared by status read
// - status bit 1 records line B firing, cleared by status read
// - status bit 2 records zoom overflow, cleared by status read
// - status bit 3 records zoom underflow, cleared by status read
// - status bit 4 records lock input seen low, cleared by read
// - latch select zero passes timing event ORed with enabled error sources
// - latch select one captures event rising edge in a flip-flop
// - latched line A holds until status register is read
// - line A pin is active low open drain
// - control bit 1 enables overflow as line A source
// - control bit 2 enables underflow as line A source
// - control bit 3 enables lock input as line A source
// - control bit 4 inverts the timing event before use
//
// Decided for this implementation: the APB interface to the registers.
`include "irq_status_defines.vh"

module display_interrupt_status_ctrl #(
  parameter EVENTS = 8
) (
  // clock and reset
  input  wire              MCLK,
  input  wire              RST_B,
  // apb slave
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [11:0]       PADDR,
  input  wire [31:0]       PWDATA,
  input  wire [3:0]        PSTRB,
  output wire              PREADY,
  output reg  [31:0]       PRDATA,
  output wire              PSLVERR,
  // event sources
  input  wire [EVENTS-1:0] TIMING_EVENTS,
  input  wire              LINE_B_EVENT,
  input  wire              ZOOM_OVERFLOW_FLAG,
  input  wire              ZOOM_UNDERFLOW_FLAG,
  input  wire              DISPLAY_PLL_LOCK_IN,
  // first interrupt open-drain pin
  output wire              INTERRUPT_LINE_A_O,
  output wire              INTERRUPT_LINE_A_OE,
  // system interrupt
  output wire              IRQ
);

  //--------------------------------------------------------------------
  // bus decode
  //--------------------------------------------------------------------
  wire       access = PSEL & PENABLE;
  wire       wr     = access & PWRITE & PSTRB[0];
  wire       rd     = access & ~PWRITE;
  wire [9:0] idx    = PADDR[11:2];
  wire       hit_status = (idx == {2'b00, `REG_STATUS_IDX});
  wire       hit_ctrl   = (idx == {2'b00, `REG_LINE_A_CTRL_IDX});
  wire       hit_mask   = (idx == {2'b00, `REG_IRQ_MASK_IDX});
  wire       hit_pend   = (idx == {2'b00, `REG_IRQ_PEND_IDX});
  wire       mapped     = hit_status | hit_ctrl | hit_mask | hit_pend;

  // zero wait state, unmapped address errors
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~mapped;

  // status read completes this edge, flags clear at it
  wire status_read = rd & hit_status;

  //--------------------------------------------------------------------
  // control registers
  //--------------------------------------------------------------------
  reg [7:0]           line_a_control;
  reg [`ST_WIDTH-1:0] irq_mask;

  // software writes, low byte lane only
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      line_a_control <= `CTRL_RESET;
      irq_mask       <= `MASK_RESET;
    end else if (wr) begin
      if (hit_ctrl)
        line_a_control <= PWDATA[7:0];
      if (hit_mask)
        irq_mask <= PWDATA[`ST_WIDTH-1:0];
    end
  end

  wire       line_a_latch_select     = line_a_control[`CT_LATCH_SEL];
  wire       overflow_source_enable  = line_a_control[`CT_OFLOW_EN];
  wire       underflow_source_enable = line_a_control[`CT_UFLOW_EN];
  wire       lock_loss_source_enable = line_a_control[`CT_LOCK_EN];
  wire       timing_event_invert     = line_a_control[`CT_INVERT];
  wire [2:0] timing_event_select     = line_a_control[`CT_SEL_HI:`CT_SEL_LO];

  //--------------------------------------------------------------------
  // timing event selection and line A generation
  //--------------------------------------------------------------------
  // selector picks one event, encoding set by integrator
  wire sel_event = TIMING_EVENTS[timing_event_select];
  wire mon_event = sel_event ^ timing_event_invert;

  reg mon_prev;
  reg event_latch;

  // rising edge capture, cleared by the status read
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mon_prev    <= 1'b0;
      event_latch <= 1'b0;
    end else begin
      mon_prev <= mon_event;
      if (mon_event & ~mon_prev)
        event_latch <= 1'b1;
      else if (status_read)
        event_latch <= 1'b0;
    end
  end

  // enabled error sources
  wire err_src = (overflow_source_enable  & ZOOM_OVERFLOW_FLAG)
               | (underflow_source_enable & ZOOM_UNDERFLOW_FLAG)
               | (lock_loss_source_enable & ~DISPLAY_PLL_LOCK_IN);

  // flow-through or latched, ORed with errors
  wire line_a = (line_a_latch_select ? event_latch : mon_event) | err_src;

  // active low open drain: drive low only when asserted
  assign INTERRUPT_LINE_A_O  = 1'b0;
  assign INTERRUPT_LINE_A_OE = line_a;

  //--------------------------------------------------------------------
  // sticky status flags
  //--------------------------------------------------------------------
  wire [`ST_WIDTH-1:0] status;
  wire [`ST_WIDTH-1:0] status_set;

  assign status_set[`ST_LINE_A] = line_a;
  assign status_set[`ST_LINE_B] = LINE_B_EVENT;
  assign status_set[`ST_OFLOW]  = ZOOM_OVERFLOW_FLAG;
  assign status_set[`ST_UFLOW]  = ZOOM_UNDERFLOW_FLAG;
  assign status_set[`ST_LOCK]   = ~DISPLAY_PLL_LOCK_IN;

  // read clears only the flags it reported, so an event that lands
  // after the setup capture is kept for the next read
  genvar g;
  generate
    for (g = 0; g < `ST_WIDTH; g = g + 1) begin : g_flag
      sticky_flag u_flag (
        .MCLK  (MCLK),
        .RST_B (RST_B),
        .set   (status_set[g]),
        .clear (status_read & PRDATA[g]),
        .flag  (status[g])
      );
    end
  endgenerate

  //--------------------------------------------------------------------
  // system interrupt and read data
  //--------------------------------------------------------------------
  wire [`ST_WIDTH-1:0] pending = status & irq_mask;
  assign IRQ = |pending;

  // read data registered at the setup phase edge, one edge before the access completes
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B)
      PRDATA <= 32'h0000_0000;
    else if (PSEL & ~PENABLE & ~PWRITE) begin
      if (hit_status)
        PRDATA <= {27'h0000000, status};
      else if (hit_ctrl)
        PRDATA <= {24'h000000, line_a_control};
      else if (hit_mask)
        PRDATA <= {27'h0000000, irq_mask};
      else if (hit_pend)
        PRDATA <= {27'h0000000, pending};
      else
        PRDATA <= 32'h0000_0000;
    end
  end

endmodule // display_interrupt_status_ctrl

// ### testbench/irq_status_sva.sv
// assertions on line A and status reads at the block ports
module irq_status_sva #(parameter EVENTS = 8) (
  // clock, reset and apb request
  input wire logic              MCLK, RST_B, PSEL, PENABLE, PWRITE,
  input wire logic [11:0]       PADDR,
  input wire logic [31:0]       PWDATA, PRDATA,
  input wire logic [3:0]        PSTRB,
  // sources and pin
  input wire logic [EVENTS-1:0] TIMING_EVENTS,
  input wire logic              ZOOM_OVERFLOW_FLAG, ZOOM_UNDERFLOW_FLAG, DISPLAY_PLL_LOCK_IN,
  input wire logic              INTERRUPT_LINE_A_O, INTERRUPT_LINE_A_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl;
  wire wc = PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == 12'h01C;
  wire ss = PSEL && !PENABLE && !PWRITE && PADDR == 12'h018;
  wire rs = PSEL && PENABLE && !PWRITE && PADDR == 12'h018;
  wire oe = INTERRUPT_LINE_A_OE;
  // shadow of the line A control register
  always_ff @(posedge MCLK or negedge RST_B)
    if (!RST_B) ctl <= 8'h00;
    else if (wc) ctl <= PWDATA[7:0];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  chk_pin_low: assert property (!INTERRUPT_LINE_A_O) else $error("pin driven high");
  chk_flow_event: assert property (!ctl[0] && ctl[3:1] == 3'h0
    |-> oe == (TIMING_EVENTS[ctl[7:5]] ^ ctl[4])) else $error("flow-through");
  chk_latch_hold: assert property (ctl[0] && ctl[3:1] == 3'h0 && oe && !rs && !wc
    |=> oe) else $error("latched line dropped");
  chk_ovf_src: assert property (ctl[1] && ZOOM_OVERFLOW_FLAG |-> oe) else $error("ovf");
  chk_unf_src: assert property (ctl[2] && ZOOM_UNDERFLOW_FLAG |-> oe) else $error("unf");
  chk_lock_src:
    assert property (ctl[3] && !DISPLAY_PLL_LOCK_IN |-> oe) else $error("lock source");
  chk_ovf_status:
    assert property (ss && $past(ZOOM_OVERFLOW_FLAG) |=> PRDATA[2]) else $error("ovf bit");
  chk_lock_status:
    assert property (ss && !$past(DISPLAY_PLL_LOCK_IN) |=> PRDATA[4]) else $error("lock bit");
endmodule // irq_status_sva

bind display_interrupt_status_ctrl irq_status_sva #(.EVENTS(EVENTS)) u_irq_status_sva (
  .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSTRB(PSTRB),
  .TIMING_EVENTS(TIMING_EVENTS), .ZOOM_OVERFLOW_FLAG(ZOOM_OVERFLOW_FLAG),
  .ZOOM_UNDERFLOW_FLAG(ZOOM_UNDERFLOW_FLAG), .DISPLAY_PLL_LOCK_IN(DISPLAY_PLL_LOCK_IN),
  .INTERRUPT_LINE_A_O(INTERRUPT_LINE_A_O), .INTERRUPT_LINE_A_OE(INTERRUPT_LINE_A_OE));

// ### testbench/irq_host_model.sv
// host view of the open-drain line A pin with its pull-up
module irq_host_model (
  input  wire logic drv_o, drv_oe,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin rests at the pull-up level
  assign pin = drv_oe ? drv_o : 1'h1;
endmodule // irq_host_model

// ### testbench/testbench.sv
// self-checking bench of the interrupt status block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic        lb = 0, ov = 0, un = 0, lk = 1, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [7:0]  ev = 0;
  wire         pready, pslverr, lo, loe, irq, pin;
  wire  [31:0] prdata;
  int          bad_count = 0, n_tests = 0;
  // control, events, overflow, underflow, lock, expected drive
  logic [19:0] rows [15] = '{20'h00013, 20'h00FE2, 20'h10FE3, 20'h0200B, 20'h0000A,
    20'h04007, 20'h08001, 20'h20023, 20'h40043, 20'h60083, 20'h80103, 20'hA0203,
    20'hC0403, 20'hE0803, 20'h00000};
  display_interrupt_status_ctrl u_display_interrupt_status_ctrl (
    .MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .TIMING_EVENTS(ev), .LINE_B_EVENT(lb), .ZOOM_OVERFLOW_FLAG(ov),
    .ZOOM_UNDERFLOW_FLAG(un), .DISPLAY_PLL_LOCK_IN(lk), .INTERRUPT_LINE_A_O(lo),
    .INTERRUPT_LINE_A_OE(loe), .IRQ(irq));
  irq_host_model u_irq_host_model (.drv_o(lo), .drv_oe(loe), .pin(pin));
  initial forever #12.5 mclk = ~mclk;
  // cycle ceiling against hangs
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1;
    apb(0, 12'h01C, 0);
    chk("ctrl", rd, 0);
    foreach (rows[i]) begin
      apb(1, 12'h01C, rows[i][19:12]);
      @(posedge mclk);
      {ev, ov, un, lk} <= rows[i][11:1];
      @(posedge mclk);
      #1;
      chk("oe", loe, rows[i][0]);
      chk("pin", pin, !rows[i][0]);
    end
    chk("irq", irq, 0);
    lk <= 1;
    repeat (2) apb(0, 12'h018, 0);
    chk("status", rd, 0);
    {lb, ov, un, lk} <= 4'hE;
    // events held over two reads stay recorded once more
    for (int k = 0; k < 4; k++) begin
      apb(0, 12'h018, 0);
      if (k == 1) {lb, ov, un, lk} <= 4'h1;
      chk("status", rd, k < 3 ? 32'h1E : 32'h0);
    end
    ev <= 1;
    apb(0, 12'h018, 0);
    chk("status", rd, 1);
    apb(1, 12'h01C, 1);
    ev <= 0;
    @(posedge mclk);
    ev <= 1;
    @(posedge mclk);
    ev <= 0;
    repeat (3) @(posedge mclk);
    #1;
    chk("latch", loe, 1);
    apb(0, 12'h018, 0);
    #1;
    chk("latch", loe, 0);
    apb(1, 12'h024, 32'h04);
    ov <= 1;
    apb(0, 12'h028, 0);
    ov <= 0;
    chk("pending", rd, 32'h04);
    chk("irq", irq, 1);
    apb(0, 12'h018, 0);
    #1;
    chk("irq", irq, 0);
    apb(0, 12'h040, 0);
    chk("err", {er, rd[30:0]}, 32'h80000000);
    end_of_test();
  end
endmodule // testbench
